/* File: rtl/swp_pkg.sv */
package swp_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE = 8'h42;
  localparam logic [7:0] OP_ANY_REG_WRITE = 8'h71;
  localparam logic [7:0] OP_SERIAL_NUM_WRITE = 8'hc2;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_STATUS_ONE_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_TWO_READ = 8'h07;
  localparam logic [7:0] OP_ANY_REG_READ = 8'h65;
  localparam logic [7:0] OP_CRC_PAUSE = 8'hb0;
  localparam logic [7:0] OP_CRC_RESUME = 8'h30;
  localparam logic [7:0] OP_CRC_CALC = 8'h5b;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [23:0] ADDR_SR1_NV = 24'h000000;
  localparam logic [23:0] ADDR_SR1_V = 24'h070000;
  localparam logic [23:0] ADDR_SR2_A = 24'h000001;
  localparam logic [23:0] ADDR_SR2_B = 24'h070001;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SR1_LOCK_BIT = 7;
  localparam int SR1_BOTTOM_BIT = 5;
  localparam int SR1_SIZE_HI = 4;
  localparam int SR1_SIZE_LO = 2;
  localparam int SR1_LATCH_BIT = 1;
  localparam int SR1_BUSY_BIT = 0;
  localparam int SR2_SUSPENDED_BIT = 4;
  localparam int SR2_ABORTED_BIT = 3;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_BOTTOM = 1'b0;
  localparam logic [2:0] RST_SIZE = 3'h0;

  // ----------------------------------------------------------------
  // Protection geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_ALL = 3'h7;
  localparam logic [20:0] ARRAY_BYTES = 21'h100000;
  localparam logic [20:0] SMALLEST_SPAN = 21'h004000;
  localparam logic [24:0] CRC_MIN_GAP = 25'h0000003;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [23:0] end_addr;
    logic [7:0] data;
  } swp_cmd_s;

  typedef enum logic [1:0] {
    GRANT_MEM,
    GRANT_CFG,
    GRANT_AUX
  } swp_grant_e;

  typedef struct packed {
    logic valid;
    swp_grant_e kind;
    logic [23:0] addr;
    logic [7:0] data;
  } swp_grant_s;

  typedef enum logic [1:0] {
    CRC_IDLE,
    CRC_RUN,
    CRC_PAUSED
  } swp_crc_e;

endpackage

/* File: rtl/swp_status_protect.sv */
`timescale 1ns/1ps
// Behaviour
// RL1: Lock bit set and protect pin low: status and config writes ignored.
// RL2: Lock bit clear: registers writable whatever the protect pin level.
// RL3: Bottom select 0: sizes 1..6 guard top fraction; 0 none, 7 all.
// RL4: Bottom select 1: sizes 1..6 guard lowest fraction from zero; 7 all.
// RL5: Memory writes inside the guarded range are refused always.
// RL6: Latch clear: every array and register write rejected.
// RL7: Only the set-latch command sets the latch.
// RL8: Latch cleared at chip select rise after the five listed opcodes.
// RL9: Plain memory writes leave the latch untouched.
// RL10: Latch returns to 0 after every reset.
// RL11: Busy is 1 only while a checksum run is active.
// RL12: While busy only status reads, pause and reset pair are accepted.
// RL13: Host must not poll busy during power-up or reset.
// RL14: Busy returns to 0 after every reset.
// RL15: Checksum flags readable by own opcode or two mirrored addresses.
// RL16: Pause during an active run sets the suspended flag.
// RL17: Resume clears the suspended flag.
// RL18: Suspended flag cleared by every reset.
// RL19: Aborted flag reads 1 after an abort; other bits read 0.
// RL20: Status one layout: lock 7, bottom 5, size 4:2, latch 1, busy 0.
// RL21: End below start plus 3 aborts; a good start or reset clears it.
// RL22: Rejected writes vanish silently with no extra flag; writes refused while busy pulse cmd_ignored.
module swp_status_protect (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n_pin,
  input wire logic wp_n_pin,
  input wire logic cmd_strobe,
  input swp_pkg::swp_cmd_s cmd_in,
  input wire logic crc_done,
  input wire logic [23:0] reg_read_addr,
  output logic [7:0] reg_read_data,
  output logic reg_read_hit,
  output logic [7:0] status_one,
  output logic [7:0] status_two,
  output swp_pkg::swp_grant_s write_grant,
  output logic crc_run,
  output logic crc_paused,
  output logic soft_reset,
  output logic cmd_ignored
);

  // ----------------------------------------------------------------
  // Range check
  // ----------------------------------------------------------------
  function automatic logic in_guard(input logic [2:0] size, input logic bottom,
                                    input logic [23:0] addr);
    logic [20:0] span;
    logic [20:0] a;
    span = 21'h000000;
    a = {1'b0, addr[19:0]};
    if (size == swp_pkg::SIZE_NONE) begin
      in_guard = 1'b0;
    end else if (size == swp_pkg::SIZE_ALL) begin
      in_guard = 1'b1;
    end else begin
      span = swp_pkg::SMALLEST_SPAN << (size - 3'h1);
      if (bottom) begin
        in_guard = a < span; // RL4
      end else begin
        in_guard = a >= (swp_pkg::ARRAY_BYTES - span); // RL3
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Register address decode
  // ----------------------------------------------------------------
  function automatic logic is_sr1_addr(input logic [23:0] addr);
    is_sr1_addr = (addr == swp_pkg::ADDR_SR1_NV) || (addr == swp_pkg::ADDR_SR1_V);
  endfunction

  function automatic logic is_sr2_addr(input logic [23:0] addr);
    is_sr2_addr = (addr == swp_pkg::ADDR_SR2_A) || (addr == swp_pkg::ADDR_SR2_B); // RL15
  endfunction

  // ----------------------------------------------------------------
  // Link domain capture
  // ----------------------------------------------------------------
  swp_pkg::swp_cmd_s cmd_hold;
  logic cmd_toggle;

  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      cmd_hold <= '0;
    end else if (cmd_strobe) begin
      cmd_hold <= cmd_in;
    end
  end

  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      cmd_toggle <= 1'b0;
    end else if (cmd_strobe) begin
      cmd_toggle <= ~cmd_toggle;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cs_sync;
  logic [2:0] wp_sync;
  logic [2:0] tog_sync;
  logic cs_lvl;
  logic wp_lvl;
  logic tog_lvl;
  logic tog_seen;

  // Held word settles long before its toggle arrives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_sync <= 3'h7;
      wp_sync <= 3'h7;
      tog_sync <= 3'h0;
    end else if (ce) begin
      cs_sync <= {cs_sync[1:0], cs_n_pin};
      wp_sync <= {wp_sync[1:0], wp_n_pin};
      tog_sync <= {tog_sync[1:0], cmd_toggle};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_lvl <= 1'b1;
      wp_lvl <= 1'b1;
      tog_lvl <= 1'b0;
    end else if (ce) begin
      if (cs_sync[1] == cs_sync[2]) begin
        cs_lvl <= cs_sync[2];
      end
      if (wp_sync[1] == wp_sync[2]) begin
        wp_lvl <= wp_sync[2];
      end
      if (tog_sync[1] == tog_sync[2]) begin
        tog_lvl <= tog_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  swp_pkg::swp_crc_e crc_state;
  logic latch;
  logic lock;
  logic bottom;
  logic [2:0] size;
  logic aborted;
  logic reset_armed;
  logic busy;
  logic cs_rise;
  logic tog_now;
  logic exec;
  logic busy_ok;
  logic accept;
  logic regs_open;
  logic sr1_addr;
  logic sr2_addr;
  logic sr1_write;
  logic cfg_write;
  logic aux_write;
  logic mem_write;
  logic latch_clear_op;
  logic crc_short;
  logic [7:0] op;

  assign op = cmd_hold.opcode;
  assign busy = (crc_state == swp_pkg::CRC_RUN); // RL11

  always_comb begin
    cs_rise = (cs_sync[1] == cs_sync[2]) && cs_sync[2] && !cs_lvl;
    tog_now = (tog_sync[1] == tog_sync[2]) ? tog_sync[2] : tog_lvl;
    exec = cs_rise && (tog_now != tog_seen);
    sr1_addr = is_sr1_addr(cmd_hold.addr);
    sr2_addr = is_sr2_addr(cmd_hold.addr);
    // Any-register reads pass while busy only at status addresses
    busy_ok = (op == swp_pkg::OP_STATUS_ONE_READ) || (op == swp_pkg::OP_STATUS_TWO_READ) ||
              ((op == swp_pkg::OP_ANY_REG_READ) && (sr1_addr || sr2_addr)) ||
              (op == swp_pkg::OP_CRC_PAUSE) || (op == swp_pkg::OP_RESET_ARM) ||
              (op == swp_pkg::OP_RESET_GO); // RL12
    accept = exec && (!busy || busy_ok); // RL12
    regs_open = !lock || wp_lvl; // RL1 RL2
    sr1_write = accept && latch && regs_open && ((op == swp_pkg::OP_STATUS_WRITE) ||
                ((op == swp_pkg::OP_ANY_REG_WRITE) && sr1_addr)); // RL6 RL22
    cfg_write = accept && latch && regs_open && (op == swp_pkg::OP_ANY_REG_WRITE) &&
                !sr1_addr && !sr2_addr; // RL1 RL6
    aux_write = accept && latch && ((op == swp_pkg::OP_SPECIAL_SECTOR_WRITE) ||
                (op == swp_pkg::OP_SERIAL_NUM_WRITE)); // RL6
    mem_write = accept && latch && (op == swp_pkg::OP_MEM_WRITE) &&
                !in_guard(size, bottom, cmd_hold.addr); // RL5 RL6 RL22
    latch_clear_op = (op == swp_pkg::OP_CLEAR_LATCH) || (op == swp_pkg::OP_STATUS_WRITE) ||
                     (op == swp_pkg::OP_SPECIAL_SECTOR_WRITE) ||
                     (op == swp_pkg::OP_ANY_REG_WRITE) || (op == swp_pkg::OP_SERIAL_NUM_WRITE);
    crc_short = {1'b0, cmd_hold.end_addr} < ({1'b0, cmd_hold.addr} + swp_pkg::CRC_MIN_GAP);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_seen <= 1'b0;
    end else if (ce && cs_rise) begin
      tog_seen <= tog_now;
    end
  end

  // ----------------------------------------------------------------
  // Software reset pair
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_armed <= 1'b0;
      soft_reset <= 1'b0;
    end else if (ce) begin
      soft_reset <= accept && reset_armed && (op == swp_pkg::OP_RESET_GO);
      if (accept) begin
        reset_armed <= (op == swp_pkg::OP_RESET_ARM);
      end
    end
  end

  // ----------------------------------------------------------------
  // Write enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch <= 1'b0; // RL10
    end else if (ce) begin
      if (soft_reset) begin
        latch <= 1'b0; // RL10
      end else if (accept && (op == swp_pkg::OP_SET_LATCH)) begin
        latch <= 1'b1; // RL7
      end else if (accept && latch_clear_op) begin
        latch <= 1'b0; // RL8
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock <= swp_pkg::RST_LOCK;
      bottom <= swp_pkg::RST_BOTTOM;
      size <= swp_pkg::RST_SIZE;
    end else if (ce && sr1_write) begin
      lock <= cmd_hold.data[swp_pkg::SR1_LOCK_BIT];
      bottom <= cmd_hold.data[swp_pkg::SR1_BOTTOM_BIT];
      size <= cmd_hold.data[swp_pkg::SR1_SIZE_HI:swp_pkg::SR1_SIZE_LO];
    end
  end

  // ----------------------------------------------------------------
  // Checksum run control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_state <= swp_pkg::CRC_IDLE; // RL14 RL18
    end else if (ce) begin
      if (soft_reset) begin
        crc_state <= swp_pkg::CRC_IDLE; // RL14 RL18
      end else begin
        case (crc_state)
          swp_pkg::CRC_IDLE: begin
            if (accept && (op == swp_pkg::OP_CRC_CALC) && !crc_short) begin
              crc_state <= swp_pkg::CRC_RUN; // RL11
            end
          end
          swp_pkg::CRC_RUN: begin
            if (accept && (op == swp_pkg::OP_CRC_PAUSE)) begin
              crc_state <= swp_pkg::CRC_PAUSED; // RL16
            end else if (crc_done) begin
              crc_state <= swp_pkg::CRC_IDLE;
            end
          end
          swp_pkg::CRC_PAUSED: begin
            if (accept && (op == swp_pkg::OP_CRC_RESUME)) begin
              crc_state <= swp_pkg::CRC_RUN; // RL17
            end
          end
          default: begin
            crc_state <= swp_pkg::CRC_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aborted <= 1'b0; // RL21
    end else if (ce) begin
      if (soft_reset) begin
        aborted <= 1'b0; // RL21
      end else if (accept && (op == swp_pkg::OP_CRC_CALC) &&
                   (crc_state == swp_pkg::CRC_IDLE)) begin
        aborted <= crc_short; // RL21
      end
    end
  end

  // ----------------------------------------------------------------
  // Write grants and refusals
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ignored <= 1'b0;
    end else if (ce) begin
      cmd_ignored <= exec && !accept; // RL12
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_grant <= '0;
    end else if (ce) begin
      write_grant.valid <= mem_write || cfg_write || aux_write;
      if (mem_write) begin
        write_grant.kind <= swp_pkg::GRANT_MEM; // RL9
      end else if (cfg_write) begin
        write_grant.kind <= swp_pkg::GRANT_CFG;
      end else begin
        write_grant.kind <= swp_pkg::GRANT_AUX;
      end
      write_grant.addr <= cmd_hold.addr;
      write_grant.data <= cmd_hold.data;
    end
  end

  // ----------------------------------------------------------------
  // Status views and register reads
  // ----------------------------------------------------------------
  always_comb begin
    status_one = 8'h00;
    status_one[swp_pkg::SR1_LOCK_BIT] = lock; // RL20
    status_one[swp_pkg::SR1_BOTTOM_BIT] = bottom;
    status_one[swp_pkg::SR1_SIZE_HI:swp_pkg::SR1_SIZE_LO] = size;
    status_one[swp_pkg::SR1_LATCH_BIT] = latch;
    status_one[swp_pkg::SR1_BUSY_BIT] = busy;
    status_two = 8'h00;
    status_two[swp_pkg::SR2_SUSPENDED_BIT] = (crc_state == swp_pkg::CRC_PAUSED); // RL16
    status_two[swp_pkg::SR2_ABORTED_BIT] = aborted; // RL19
  end

  assign crc_run = busy;
  assign crc_paused = (crc_state == swp_pkg::CRC_PAUSED);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_read_data <= 8'h00;
      reg_read_hit <= 1'b0;
    end else if (ce) begin
      if (is_sr1_addr(reg_read_addr)) begin
        reg_read_data <= status_one;
        reg_read_hit <= 1'b1;
      end else if (is_sr2_addr(reg_read_addr)) begin
        reg_read_data <= status_two; // RL15
        reg_read_hit <= 1'b1;
      end else begin
        reg_read_data <= 8'h00;
        reg_read_hit <= 1'b0;
      end
    end
  end

endmodule // swp_status_protect

/* File: tb/swp_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host controller on the link
// ------------------------------------------------------------
module swp_host_model (
  output logic sck,
  output logic cs_n_pin,
  output logic cmd_strobe,
  output swp_pkg::swp_cmd_s cmd_in
);
  initial begin
    sck = 1'b0;
    cs_n_pin = 1'b1;
    cmd_strobe = 1'b0;
    cmd_in = '1;
  end

  // One framed command, link clock only inside the frame
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [23:0] e,
                       input logic [7:0] d);
    swp_pkg::swp_cmd_s c;
    c = '{op, a, e, d};
    cs_n_pin = 1'b0;
    #31;
    cmd_in = c;
    cmd_strobe = 1'b1;
    #24 sck = 1'b1;
    #24 sck = 1'b0;
    cmd_strobe = 1'b0;
    cmd_in = ~c;
    #24 sck = 1'b1;
    #24 sck = 1'b0;
    #150 cs_n_pin = 1'b1;
    #800;
  endtask
endmodule // swp_host_model

/* File: tb/swp_status_protect_sva.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module swp_status_protect_sva (
  input logic clk,
  input logic resetn,
  input logic ce,
  input logic sck,
  input logic cs_n_pin,
  input logic wp_n_pin,
  input logic cmd_strobe,
  input swp_pkg::swp_cmd_s cmd_in,
  input logic crc_done,
  input logic [23:0] reg_read_addr,
  input logic [7:0] reg_read_data,
  input logic reg_read_hit,
  input logic [7:0] status_one,
  input logic [7:0] status_two,
  input swp_pkg::swp_grant_s write_grant,
  input logic crc_run,
  input logic crc_paused,
  input logic soft_reset,
  input logic cmd_ignored
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  function automatic logic guarded(input logic [7:0] s, input logic [23:0] a);
    logic [20:0] span;
    span = swp_pkg::SMALLEST_SPAN << (s[4:2] - 3'h1);
    if (s[4:2] == swp_pkg::SIZE_NONE) return 1'b0;
    if (s[4:2] == swp_pkg::SIZE_ALL) return 1'b1;
    if (s[5]) return {1'b0, a[19:0]} < span;
    return {1'b0, a[19:0]} >= swp_pkg::ARRAY_BYTES - span;
  endfunction

  wire mem_grant = write_grant.valid && write_grant.kind == swp_pkg::GRANT_MEM;
  wire cfg_grant = write_grant.valid && write_grant.kind == swp_pkg::GRANT_CFG;

  chk_sr1_layout: assert property (status_one[6] == 1'b0 && status_one[0] == crc_run)
    else $error("status one layout wrong");
  chk_sr2_layout: assert property (
    (status_two & 8'he7) == 8'h00 && status_two[4] == crc_paused)
    else $error("status two layout wrong");
  chk_mem_latch: assert property (mem_grant |-> $past(status_one[1]))
    else $error("write granted with latch clear");
  chk_latch_kept: assert property (mem_grant |-> status_one[1])
    else $error("memory write cleared latch");
  chk_cfg_clears: assert property (cfg_grant |-> !status_one[1])
    else $error("register write kept latch");
  chk_lock_holds: assert property (cfg_grant |->
    !($past(status_one[7]) && !wp_n_pin && !$past(wp_n_pin, 8)))
    else $error("locked register written");
  chk_range_guard: assert property (
    mem_grant |-> !guarded($past(status_one), write_grant.addr))
    else $error("guarded address written");
  chk_busy_refuse: assert property (cmd_ignored |-> $past(crc_run) && !write_grant.valid)
    else $error("refusal while idle");
  chk_busy_nogrant: assert property (write_grant.valid |-> !$past(crc_run))
    else $error("grant while busy");
  chk_soft_clears: assert property (soft_reset |->
    ##[0:1] (status_one[1:0] == 2'b00 && status_two == 8'h00))
    else $error("soft reset left volatile bits");
  chk_read_two: assert property ($past(reg_read_addr) == swp_pkg::ADDR_SR2_B |->
    reg_read_hit && reg_read_data == $past(status_two))
    else $error("mirror read wrong");
endmodule // swp_status_protect_sva

bind swp_status_protect swp_status_protect_sva chk_u (
  .clk(clk), .resetn(resetn), .ce(ce), .sck(sck), .cs_n_pin(cs_n_pin), .wp_n_pin(wp_n_pin),
  .cmd_strobe(cmd_strobe), .cmd_in(cmd_in), .crc_done(crc_done), .reg_read_addr(reg_read_addr),
  .reg_read_data(reg_read_data), .reg_read_hit(reg_read_hit), .status_one(status_one),
  .status_two(status_two), .write_grant(write_grant), .crc_run(crc_run),
  .crc_paused(crc_paused), .soft_reset(soft_reset), .cmd_ignored(cmd_ignored)
);

/* File: tb/swp_status_protect_tb.sv */
`timescale 1ns/1ps
module swp_status_protect_tb;
  logic clk = 1'b0;
  logic resetn, ce, wp_n_pin, crc_done, sck, cs_n_pin, cmd_strobe, reg_read_hit;
  logic crc_run, crc_paused, soft_reset, cmd_ignored;
  logic [23:0] reg_read_addr;
  logic [7:0] reg_read_data, status_one, status_two;
  swp_pkg::swp_cmd_s cmd_in;
  swp_pkg::swp_grant_s write_grant;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [33:0] exp_q [$];
  logic [7:0] clr_op [5] = '{8'h04, 8'h01, 8'h42, 8'h71, 8'hc2};
  logic [1:0] clr_kind [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};

  always #50 clk = ~clk;

  swp_host_model host_u (.sck(sck), .cs_n_pin(cs_n_pin), .cmd_strobe(cmd_strobe), .cmd_in(cmd_in));
  swp_status_protect dut_u (
    .clk(clk), .resetn(resetn), .ce(ce), .sck(sck), .cs_n_pin(cs_n_pin), .wp_n_pin(wp_n_pin),
    .cmd_strobe(cmd_strobe), .cmd_in(cmd_in), .crc_done(crc_done), .reg_read_addr(reg_read_addr),
    .reg_read_data(reg_read_data), .reg_read_hit(reg_read_hit), .status_one(status_one),
    .status_two(status_two), .write_grant(write_grant), .crc_run(crc_run),
    .crc_paused(crc_paused), .soft_reset(soft_reset), .cmd_ignored(cmd_ignored)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [33:0] got, input logic [33:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Kind 3 marks a refused command
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                      input logic [1:0] k, input bit go);
    if (go) exp_q.push_back({k, (k == 2'h0) ? a : 24'h0, d});
    host_u.frame(op, a, a, d);
  endtask

  task automatic latch();
    host_u.frame(swp_pkg::OP_SET_LATCH, 24'h0, 24'h0, 8'h0);
  endtask

  task automatic rd(input logic [23:0] a, input logic [7:0] want);
    logic hit;
    hit = a inside {swp_pkg::ADDR_SR1_NV, swp_pkg::ADDR_SR1_V, swp_pkg::ADDR_SR2_A,
                    swp_pkg::ADDR_SR2_B};
    @(posedge clk) #2 reg_read_addr = a;
    @(posedge clk) #2 check({25'h0, reg_read_hit, reg_read_data}, {25'h0, hit, want});
  endtask

  task automatic take(input logic [33:0] got);
    if (exp_q.size() == 0) check(34'h1, 34'h0);
    else check(got, exp_q.pop_front());
  endtask

  // ------------------------------------------------------------
  // Event monitor
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (resetn === 1'b1) begin
      if (write_grant.valid === 1'b1) take({write_grant.kind,
        (write_grant.kind == swp_pkg::GRANT_MEM) ? write_grant.addr : 24'h0, write_grant.data});
      if (cmd_ignored === 1'b1) take({2'h3, 32'h0});
      if (soft_reset === 1'b1) take({2'h3, 32'hff});
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    int i, b, s;
    logic [23:0] span, ina, outa;
    logic [7:0] sr;
    void'($urandom(35307));
    resetn = 1'b0;
    ce = 1'b1;
    wp_n_pin = 1'b0;
    crc_done = 1'b0;
    reg_read_addr = 24'h123456;
    repeat (20) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (6) @(posedge clk);
    rd(swp_pkg::ADDR_SR1_NV, 8'h00);
    rd(swp_pkg::ADDR_SR2_A, 8'h00);
    rd(24'h000005, 8'h00);
    $display("test reset values done");
    send(swp_pkg::OP_MEM_WRITE, 24'h000100, 8'h5a, 2'h0, 0);
    latch();
    rd(swp_pkg::ADDR_SR1_V, 8'h02);
    for (i = 0; i < 2; i++) send(swp_pkg::OP_MEM_WRITE, 24'($urandom), 8'($urandom), 2'h0, 1);
    rd(swp_pkg::ADDR_SR1_V, 8'h02);
    for (i = 0; i < 5; i++) begin
      latch();
      send(clr_op[i], (i == 3) ? 24'h000002 : 24'h0, 8'h00, clr_kind[i], i > 1);
      rd(swp_pkg::ADDR_SR1_V, 8'h00);
    end
    $display("test latch done");
    for (b = 0; b < 2; b++) begin
      for (s = 0; s < 8; s++) begin
        sr = {2'b00, b[0], s[2:0], 2'b00};
        span = 24'h004000 << (s - 1);
        ina = b ? span - 24'h1 : 24'h100000 - span;
        outa = b ? span : ina - 24'h1;
        latch();
        send(swp_pkg::OP_STATUS_WRITE, 24'h0, sr, swp_pkg::GRANT_CFG, 0);
        rd(swp_pkg::ADDR_SR1_V, sr);
        latch();
        send(swp_pkg::OP_MEM_WRITE, outa, 8'($urandom), 2'h0, s != 7);
        send(swp_pkg::OP_MEM_WRITE, ina, 8'($urandom), 2'h0, s == 0);
      end
    end
    latch();
    send(swp_pkg::OP_STATUS_WRITE, 24'h0, 8'h80, swp_pkg::GRANT_CFG, 0);
    latch();
    send(swp_pkg::OP_STATUS_WRITE, 24'h0, 8'h1c, swp_pkg::GRANT_CFG, 0);
    send(swp_pkg::OP_ANY_REG_WRITE, swp_pkg::ADDR_SR1_V, 8'h1c, swp_pkg::GRANT_CFG, 0);
    send(swp_pkg::OP_CLEAR_LATCH, 24'h0, 8'h0, 2'h0, 0);
    rd(swp_pkg::ADDR_SR1_V, 8'h80);
    @(posedge clk) #2 wp_n_pin = 1'b1;
    latch();
    send(swp_pkg::OP_STATUS_WRITE, 24'h0, 8'h00, swp_pkg::GRANT_CFG, 0);
    rd(swp_pkg::ADDR_SR1_V, 8'h00);
    $display("test protection done");
    latch();
    host_u.frame(swp_pkg::OP_CRC_CALC, 24'h100, 24'h102, 8'h0);
    rd(swp_pkg::ADDR_SR2_A, 8'h08);
    host_u.frame(swp_pkg::OP_CRC_CALC, 24'h100, 24'h103, 8'h0);
    rd(swp_pkg::ADDR_SR1_V, 8'h03);
    rd(swp_pkg::ADDR_SR2_B, 8'h00);
    send(swp_pkg::OP_MEM_WRITE, 24'h10, 8'h00, 2'h3, 1);
    send(swp_pkg::OP_ANY_REG_READ, 24'h000002, 8'h00, 2'h3, 1);
    host_u.frame(swp_pkg::OP_ANY_REG_READ, swp_pkg::ADDR_SR2_B, 24'h0, 8'h0);
    host_u.frame(swp_pkg::OP_STATUS_ONE_READ, 24'h0, 24'h0, 8'h0);
    host_u.frame(swp_pkg::OP_CRC_PAUSE, 24'h0, 24'h0, 8'h0);
    rd(swp_pkg::ADDR_SR2_A, 8'h10);
    host_u.frame(swp_pkg::OP_CRC_RESUME, 24'h0, 24'h0, 8'h0);
    rd(swp_pkg::ADDR_SR2_A, 8'h00);
    @(posedge clk) #2 crc_done = 1'b1;
    @(posedge clk) #2 crc_done = 1'b0;
    rd(swp_pkg::ADDR_SR1_V, 8'h02);
    host_u.frame(swp_pkg::OP_CRC_CALC, 24'h0, 24'h10, 8'h0);
    host_u.frame(swp_pkg::OP_CRC_PAUSE, 24'h0, 24'h0, 8'h0);
    exp_q.push_back({2'h3, 32'hff});
    host_u.frame(swp_pkg::OP_RESET_ARM, 24'h0, 24'h0, 8'h0);
    host_u.frame(swp_pkg::OP_RESET_GO, 24'h0, 24'h0, 8'h0);
    rd(swp_pkg::ADDR_SR1_V, 8'h00);
    rd(swp_pkg::ADDR_SR2_A, 8'h00);
    $display("test checksum done");
    latch();
    host_u.frame(swp_pkg::OP_CRC_CALC, 24'h0, 24'h10, 8'h0);
    @(posedge clk) #2 resetn = 1'b0;
    repeat (3) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (6) @(posedge clk);
    rd(swp_pkg::ADDR_SR1_V, 8'h00);
    repeat (10) @(posedge clk);
    check(34'(exp_q.size()), 34'h0);
    $display("test hard reset done");
    report_and_stop();
  end
endmodule // swp_status_protect_tb
